// File: hdl/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // raw and agreed levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge mclk)
  begin
    s1_r <= din;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (srst)
      dout <= '0;
    else
      dout <= (dout & (s2_r ^ s3_r)) | (s2_r & s3_r);
  end
endmodule : pin_sync3

// File: hdl/pwr_mode_pkg.sv
package pwr_mode_pkg;
  // register offsets (byte addresses)
  localparam logic [5:0] OFS_PCTRL = 6'h00;
  localparam logic [5:0] OFS_RUN = 6'h04;
  localparam logic [5:0] OFS_SLEEP = 6'h08;
  localparam logic [5:0] OFS_WAKE = 6'h0c;
  localparam logic [5:0] OFS_GATE = 6'h10;
  localparam logic [5:0] OFS_DIV = 6'h14;
  localparam logic [5:0] OFS_PIN_EN = 6'h18;
  localparam logic [5:0] OFS_WAKE1 = 6'h1c;
  localparam logic [5:0] OFS_BOD = 6'h20;
  localparam logic [5:0] OFS_WDCFG = 6'h24;
  localparam logic [5:0] OFS_STATUS = 6'h28;
  // power_mode_field codes
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_DEEP = 2'h1;
  localparam logic [1:0] MODE_PDOWN = 2'h2;
  // power config bits, 1 = powered down
  localparam int PD_IRC_OUT = 0;
  localparam int PD_IRC = 1;
  localparam int PD_FLASH = 2;
  localparam int PD_BOD = 3;
  localparam int PD_SYSOSC = 4;
  localparam int PD_WDO = 5;
  localparam int PD_PLL = 6;
  localparam int PD_ADC = 7;
  localparam logic [7:0] RUN_RST = 8'hf0;
  localparam logic [7:0] SLEEP_RST = 8'hff;
  localparam logic [7:0] WAKE_RST = 8'hf0;
  localparam logic [15:0] GATE_RST = 16'h001f;
  localparam logic [7:0] DIV_RST = 8'h01;
  // bus_clock_gate bit of the watchdog
  localparam int GATE_WDT = 15;
  // wake-up register 1 bits, also irq_enabled bits 8..11
  localparam int W1_BOD = 0;
  localparam int W1_WDT = 1;
  localparam int W1_USB = 2;
  localparam int W1_GRP = 3;
  // brownout_control bits
  localparam int BOD_RST_EN = 0;
  localparam int BOD_IRQ_SEL = 1;
  // watchdog_config_register bits
  localparam int WD_IRQ_EN = 0;
  localparam int WD_RST_EN = 1;
  localparam int WD_SRC_WDO = 2;
  localparam int WD_FREEZE = 5;
  // wake latency counts
  localparam logic [5:0] DS_WAKE_CYC = 6'h08;
  localparam logic [5:0] PD_WAKE_CYC = 6'h20;
  localparam logic [5:0] DS_WDO_TICKS = 6'h02;
  localparam logic [5:0] PD_WDO_TICKS = 6'h06;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_SLEEP = 2'b01,
    ST_DEEP = 2'b10,
    ST_WAKE = 2'b11
  } pm_state_type;
endpackage : pwr_mode_pkg

// File: hdl/reduced_power_mode_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// - sleep stops only the processor clock
// - enabled interrupt or reset ends sleep
// - interrupt wake keeps run config; reset defaults
// - all low power modes retain register state
// - deep-sleep: analog off, rc on, flash standby
// - main and peripheral clocks off, watchdog excepted
// - frozen rc watchdog source keeps rc running
// - enabled pin interrupts wake deep modes
// - brownout wakes only if kept powered
// - watchdog wakes only if its oscillator runs
// - usb and gpio group also wake
// - running watchdog oscillator paces wake latency while the watchdog clock is kept
// - power-down also stops rc and flash
module reduced_power_mode_control (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // processor core
  input wire logic core_wfi,
  input wire logic deep_idle_select,
  input wire logic core_irq_pending,
  input wire logic [11:0] irq_enabled,
  // wake sources from pins and analog blocks
  input wire logic [7:0] pin_irq,
  input wire logic bod_trip,
  input wire logic wdt_irq,
  input wire logic wdt_reset,
  input wire logic usb_wake,
  input wire logic gpio_group_irq,
  input wire logic wdosc_clk,
  // clock and power controls
  output logic cpu_clk_en,
  output logic main_clk_en,
  output logic [15:0] periph_clk_en,
  output logic wdt_clk_en,
  output logic [7:0] bus_div,
  output logic [7:0] analog_pd,
  output logic irc_out_en,
  output logic flash_standby,
  output logic reset_req
);
  pwr_mode_pkg::pm_state_type state_r;
  pwr_mode_pkg::pm_state_type state_nxt;
  logic [1:0] mode_r;
  logic pdown_r;
  logic [7:0] run_cfg_r;
  logic [7:0] sleep_cfg_r;
  logic [7:0] wake_cfg_r;
  logic [15:0] gate_r;
  logic [7:0] div_r;
  logic [7:0] pin_en_r;
  logic [3:0] wake1_r;
  logic [1:0] bodctl_r;
  logic [5:0] wdcfg_r;
  logic [13:0] ext_s;
  logic wdo_s_r;
  logic wdo_rise;
  logic deep_st;
  logic bod_on;
  logic wdo_on;
  logic rc_frozen;
  logic wdt_keep;
  logic deep_wake;
  logic timer_load;
  logic timer_tick;
  logic timer_done;
  logic [5:0] timer_val;
  logic entry_block;
  logic pdown_nxt;

  // every external event is synchronised before use
  pin_sync3 #(.W(14)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .din({wdosc_clk, gpio_group_irq, usb_wake, wdt_reset, wdt_irq, bod_trip, pin_irq}),
    .dout(ext_s)
  );

  assign deep_st = state_r == pwr_mode_pkg::ST_DEEP;
  assign pdown_nxt = deep_st ? pdown_r : mode_r == pwr_mode_pkg::MODE_PDOWN;
  assign bod_on = !sleep_cfg_r[pwr_mode_pkg::PD_BOD];
  assign wdo_on = !sleep_cfg_r[pwr_mode_pkg::PD_WDO];
  assign rc_frozen = wdcfg_r[pwr_mode_pkg::WD_FREEZE] && !wdcfg_r[pwr_mode_pkg::WD_SRC_WDO];
  // watchdog clock survives deep modes from its own osc or a frozen rc
  assign wdt_keep = (wdo_on && wdcfg_r[pwr_mode_pkg::WD_SRC_WDO]) || rc_frozen;
  // power-down with a frozen rc source would never settle, so it is refused
  assign entry_block = mode_r == pwr_mode_pkg::MODE_PDOWN && rc_frozen;

  // wake sources in deep modes
  always_comb
  begin
    deep_wake = |(ext_s[7:0] & pin_en_r & irq_enabled[7:0]);
    if (ext_s[8] && bod_on && bodctl_r[pwr_mode_pkg::BOD_IRQ_SEL] && wake1_r[pwr_mode_pkg::W1_BOD] &&
        irq_enabled[8])
      deep_wake = 1'b1;
    if (ext_s[9] && wdo_on && wdcfg_r[pwr_mode_pkg::WD_IRQ_EN] && wake1_r[pwr_mode_pkg::W1_WDT] &&
        irq_enabled[9])
      deep_wake = 1'b1;
    if (ext_s[11] && wake1_r[pwr_mode_pkg::W1_USB] && irq_enabled[10])
      deep_wake = 1'b1;
    if (ext_s[12] && wake1_r[pwr_mode_pkg::W1_GRP] && irq_enabled[11])
      deep_wake = 1'b1;
  end

  // reset requests; the system answers with srst, which restores defaults
  always_ff @(posedge mclk)
  begin
    if (srst)
      reset_req <= 1'b0;
    else
      reset_req <= (ext_s[8] && bodctl_r[pwr_mode_pkg::BOD_RST_EN] && (!deep_st || bod_on)) ||
                   (ext_s[10] && wdcfg_r[pwr_mode_pkg::WD_RST_EN] &&
                    (!deep_st || (wdo_on && gate_r[pwr_mode_pkg::GATE_WDT])));
  end

  // watchdog oscillator edge, taken from the agreed level
  always_ff @(posedge mclk)
  begin
    if (srst)
      wdo_s_r <= 1'b0;
    else
      wdo_s_r <= ext_s[13];
  end

  assign wdo_rise = ext_s[13] && !wdo_s_r;

  always_comb
  begin
    state_nxt = state_r;
    timer_load = 1'b0;
    case (state_r)
      pwr_mode_pkg::ST_ACTIVE:
      begin
        if (core_wfi && !deep_idle_select && mode_r == pwr_mode_pkg::MODE_SLEEP)
          state_nxt = pwr_mode_pkg::ST_SLEEP;
        else if (core_wfi && deep_idle_select && !entry_block &&
                 (mode_r == pwr_mode_pkg::MODE_DEEP || mode_r == pwr_mode_pkg::MODE_PDOWN))
          state_nxt = pwr_mode_pkg::ST_DEEP;
      end
      pwr_mode_pkg::ST_SLEEP:
      begin
        if (core_irq_pending)
          state_nxt = pwr_mode_pkg::ST_ACTIVE;
      end
      pwr_mode_pkg::ST_DEEP:
      begin
        if (deep_wake)
        begin
          state_nxt = pwr_mode_pkg::ST_WAKE;
          timer_load = 1'b1;
        end
      end
      default:
      begin
        if (timer_done)
          state_nxt = pwr_mode_pkg::ST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      state_r <= pwr_mode_pkg::ST_ACTIVE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      pdown_r <= 1'b0;
    else if (state_r == pwr_mode_pkg::ST_ACTIVE && state_nxt == pwr_mode_pkg::ST_DEEP)
      pdown_r <= mode_r == pwr_mode_pkg::MODE_PDOWN;
  end

  // latency: power-down waits longer; a running watchdog osc sets the pace while the watchdog clock is kept
  always_comb
  begin
    if (wdt_keep && wdo_on)
      timer_val = pdown_r ? pwr_mode_pkg::PD_WDO_TICKS : pwr_mode_pkg::DS_WDO_TICKS;
    else
      timer_val = pdown_r ? pwr_mode_pkg::PD_WAKE_CYC : pwr_mode_pkg::DS_WAKE_CYC;
  end

  // the osc is far slower than mclk, so each rise is seen once
  assign timer_tick = (wdt_keep && wdo_on) ? wdo_rise : 1'b1;

  wake_timer u_timer (
    .mclk(mclk),
    .srst(srst),
    .load(timer_load),
    .load_val(timer_val),
    .tick(timer_tick),
    .done(timer_done)
  );

  // registers; processor is stopped in low power modes so nothing is lost
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      mode_r <= pwr_mode_pkg::MODE_SLEEP;
      sleep_cfg_r <= pwr_mode_pkg::SLEEP_RST;
      wake_cfg_r <= pwr_mode_pkg::WAKE_RST;
      gate_r <= pwr_mode_pkg::GATE_RST;
      div_r <= pwr_mode_pkg::DIV_RST;
      pin_en_r <= 8'h00;
      wake1_r <= 4'h0;
      bodctl_r <= 2'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == pwr_mode_pkg::OFS_PCTRL)
        mode_r <= reg_wdata[1:0];
      else if (reg_addr == pwr_mode_pkg::OFS_SLEEP)
        sleep_cfg_r <= reg_wdata[7:0];
      else if (reg_addr == pwr_mode_pkg::OFS_WAKE)
        wake_cfg_r <= reg_wdata[7:0];
      else if (reg_addr == pwr_mode_pkg::OFS_GATE)
        gate_r <= reg_wdata[15:0];
      else if (reg_addr == pwr_mode_pkg::OFS_DIV)
        div_r <= reg_wdata[7:0];
      else if (reg_addr == pwr_mode_pkg::OFS_PIN_EN)
        pin_en_r <= reg_wdata[7:0];
      else if (reg_addr == pwr_mode_pkg::OFS_WAKE1)
        wake1_r <= reg_wdata[3:0];
      else if (reg_addr == pwr_mode_pkg::OFS_BOD)
        bodctl_r <= reg_wdata[1:0];
    end
  end

  // run config takes the wake config when leaving a deep mode
  always_ff @(posedge mclk)
  begin
    if (srst)
      run_cfg_r <= pwr_mode_pkg::RUN_RST;
    else if (timer_load)
      run_cfg_r <= wake_cfg_r;
    else if (reg_wr && reg_addr == pwr_mode_pkg::OFS_RUN)
      run_cfg_r <= reg_wdata[7:0];
  end

  // freeze bit only sets; only a reset clears it, and it locks the source
  always_ff @(posedge mclk)
  begin
    if (srst)
      wdcfg_r <= 6'h00;
    else if (reg_wr && reg_addr == pwr_mode_pkg::OFS_WDCFG)
    begin
      wdcfg_r[1:0] <= reg_wdata[1:0];
      wdcfg_r[4:3] <= reg_wdata[4:3];
      if (!wdcfg_r[pwr_mode_pkg::WD_FREEZE])
        wdcfg_r[pwr_mode_pkg::WD_SRC_WDO] <= reg_wdata[pwr_mode_pkg::WD_SRC_WDO];
      wdcfg_r[pwr_mode_pkg::WD_FREEZE] <= wdcfg_r[pwr_mode_pkg::WD_FREEZE] |
                                          reg_wdata[pwr_mode_pkg::WD_FREEZE];
    end
  end

  // read data one cycle after the strobe, zero on unmapped offsets
  always_ff @(posedge mclk)
  begin
    if (srst)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
    begin
      if (reg_addr == pwr_mode_pkg::OFS_PCTRL)
        reg_rdata <= {30'h00000000, mode_r};
      else if (reg_addr == pwr_mode_pkg::OFS_RUN)
        reg_rdata <= {24'h000000, run_cfg_r};
      else if (reg_addr == pwr_mode_pkg::OFS_SLEEP)
        reg_rdata <= {24'h000000, sleep_cfg_r};
      else if (reg_addr == pwr_mode_pkg::OFS_WAKE)
        reg_rdata <= {24'h000000, wake_cfg_r};
      else if (reg_addr == pwr_mode_pkg::OFS_GATE)
        reg_rdata <= {16'h0000, gate_r};
      else if (reg_addr == pwr_mode_pkg::OFS_DIV)
        reg_rdata <= {24'h000000, div_r};
      else if (reg_addr == pwr_mode_pkg::OFS_PIN_EN)
        reg_rdata <= {24'h000000, pin_en_r};
      else if (reg_addr == pwr_mode_pkg::OFS_WAKE1)
        reg_rdata <= {28'h0000000, wake1_r};
      else if (reg_addr == pwr_mode_pkg::OFS_BOD)
        reg_rdata <= {30'h00000000, bodctl_r};
      else if (reg_addr == pwr_mode_pkg::OFS_WDCFG)
        reg_rdata <= {26'h0000000, wdcfg_r};
      else if (reg_addr == pwr_mode_pkg::OFS_STATUS)
        reg_rdata <= {28'h0000000, entry_block, pdown_r, state_r};
      else
        reg_rdata <= 32'h00000000;
    end
  end

  // clock and power outputs
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cpu_clk_en <= 1'b1;
      main_clk_en <= 1'b1;
      periph_clk_en <= pwr_mode_pkg::GATE_RST;
      wdt_clk_en <= pwr_mode_pkg::GATE_RST[pwr_mode_pkg::GATE_WDT];
      bus_div <= pwr_mode_pkg::DIV_RST;
      analog_pd <= pwr_mode_pkg::RUN_RST;
      irc_out_en <= 1'b1;
      flash_standby <= 1'b0;
    end
    else if (state_nxt == pwr_mode_pkg::ST_ACTIVE || state_nxt == pwr_mode_pkg::ST_SLEEP)
    begin
      cpu_clk_en <= state_nxt == pwr_mode_pkg::ST_ACTIVE;
      main_clk_en <= 1'b1;
      periph_clk_en <= gate_r;
      wdt_clk_en <= gate_r[pwr_mode_pkg::GATE_WDT];
      bus_div <= div_r;
      analog_pd <= timer_load ? wake_cfg_r : run_cfg_r;
      irc_out_en <= !run_cfg_r[pwr_mode_pkg::PD_IRC_OUT];
      flash_standby <= 1'b0;
    end
    else if (state_nxt == pwr_mode_pkg::ST_WAKE)
    begin
      cpu_clk_en <= 1'b0;
      main_clk_en <= 1'b0;
      periph_clk_en <= 16'h0000;
      wdt_clk_en <= wdt_keep;
      analog_pd <= wake_cfg_r;
      irc_out_en <= 1'b0;
      flash_standby <= 1'b0;
    end
    else
    begin
      cpu_clk_en <= 1'b0;
      main_clk_en <= 1'b0;
      periph_clk_en <= {wdt_keep, 15'h0000};
      wdt_clk_en <= wdt_keep;
      analog_pd <= 8'hff;
      analog_pd[pwr_mode_pkg::PD_BOD] <= !bod_on;
      analog_pd[pwr_mode_pkg::PD_WDO] <= !wdo_on;
      analog_pd[pwr_mode_pkg::PD_IRC] <= pdown_nxt && !rc_frozen;
      analog_pd[pwr_mode_pkg::PD_FLASH] <= pdown_nxt;
      irc_out_en <= rc_frozen;
      flash_standby <= !pdown_nxt;
    end
  end

  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);

  sleep_clocks_a: assert property (state_r == pwr_mode_pkg::ST_SLEEP |-> !cpu_clk_en && main_clk_en)
    else $error("sleep must stop only the processor clock");
  sleep_wake_a: assert property (state_r == pwr_mode_pkg::ST_SLEEP && core_irq_pending
                                 |=> state_r == pwr_mode_pkg::ST_ACTIVE && cpu_clk_en)
    else $error("sleep not left on enabled interrupt");
  sleep_cfg_a: assert property (state_r == pwr_mode_pkg::ST_SLEEP ##1 state_r == pwr_mode_pkg::ST_ACTIVE
                                |-> analog_pd == run_cfg_r && bus_div == div_r)
    else $error("run configuration not kept after sleep");
  retain_regs_a: assert property (state_r != pwr_mode_pkg::ST_ACTIVE && !reg_wr |=> $stable(gate_r)
                                  && $stable(sleep_cfg_r))
    else $error("register state lost in low power mode");
  deep_analog_a: assert property (deep_st && !pdown_r && !rc_frozen ##1 deep_st
                                  |-> !analog_pd[pwr_mode_pkg::PD_IRC] && !irc_out_en && flash_standby)
    else $error("deep-sleep analog state wrong");
  deep_clocks_a: assert property (deep_st ##1 deep_st |-> !main_clk_en && !cpu_clk_en
                                  && periph_clk_en == {wdt_keep, 15'h0000})
    else $error("clocks running in deep mode");
  frozen_rc_a: assert property (deep_st && rc_frozen ##1 deep_st |-> irc_out_en && wdt_clk_en)
    else $error("frozen rc source not kept running");
  pin_wake_a: assert property (deep_st && |(ext_s[7:0] & pin_en_r & irq_enabled[7:0])
                               |=> state_r == pwr_mode_pkg::ST_WAKE)
    else $error("enabled pin did not wake");
  pdown_off_a: assert property (deep_st && pdown_r && !rc_frozen ##1 deep_st
                                |-> analog_pd[pwr_mode_pkg::PD_IRC] && analog_pd[pwr_mode_pkg::PD_FLASH])
    else $error("power-down left rc or flash on");
  pd_refuse_a: assert property (state_r == pwr_mode_pkg::ST_ACTIVE && entry_block
                                |=> state_r != pwr_mode_pkg::ST_DEEP)
    else $error("power-down entered with frozen rc source");
  wake_cfg_a: assert property (deep_st && deep_wake |=> state_r == pwr_mode_pkg::ST_WAKE && !cpu_clk_en
                               && run_cfg_r == $past(wake_cfg_r) && analog_pd == run_cfg_r)
    else $error("wake config not applied before processor clock");
endmodule : reduced_power_mode_control

// File: hdl/wake_timer.sv
`timescale 1ns/1ps
module wake_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // control
  input wire logic load,
  input wire logic [5:0] load_val,
  input wire logic tick,
  // status
  output logic done
);
  logic [5:0] cnt_r;

  always_ff @(posedge mclk)
  begin
    if (srst)
      cnt_r <= 6'h00;
    else if (load)
      cnt_r <= load_val;
    else if (tick && cnt_r != 6'h00)
      cnt_r <= cnt_r - 6'h01;
  end

  assign done = !load && cnt_r == 6'h00;
endmodule : wake_timer

// File: tb/core_irq_model.sv
`timescale 1ns/1ps
module core_irq_model (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // bench commands
  input wire logic wfi_req,
  input wire logic deep_req,
  input wire logic [11:0] irq_src,
  input wire logic [11:0] irq_enabled,
  // core side of the power block
  input wire logic cpu_clk_en,
  output logic core_wfi,
  output logic deep_idle_select,
  output logic core_irq_pending
);
  // the deep bit settles a cycle before the wfi pulse, so the block never sees both move together
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      core_wfi <= 1'b0;
      deep_idle_select <= 1'b0;
    end
    else
    begin
      deep_idle_select <= deep_req;
      core_wfi <= wfi_req && cpu_clk_en && !core_wfi;
    end
  end
  // a stopped core cannot run wfi; only controller-enabled sources reach the pending line
  always_ff @(posedge mclk)
  begin
    if (srst)
      core_irq_pending <= 1'b0;
    else
      core_irq_pending <= |(irq_src & irq_enabled);
  end
endmodule : core_irq_model

// File: tb/reduced_power_mode_control_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module reduced_power_mode_control_bench;
  logic mclk, srst, reg_wr, reg_rd, core_wfi, deep_idle_select, core_irq_pending;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [11:0] irq_enabled, src;
  logic wdt_reset, wdosc_clk, wdosc_run, wfi_req, deep_req;
  logic [1:0] wdosc_div;
  logic cpu_clk_en, main_clk_en, wdt_clk_en, irc_out_en, flash_standby, reset_req;
  logic [15:0] periph_clk_en;
  logic [7:0] bus_div, analog_pd;
  int fail_count = 0;
  int checked = 0;
  int cyc_n = 0;
  int lat_ds, lat_pd, n;

  reduced_power_mode_control DUT (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_wfi(core_wfi),
    .deep_idle_select(deep_idle_select), .core_irq_pending(core_irq_pending), .irq_enabled(irq_enabled),
    .pin_irq(src[7:0]), .bod_trip(src[8]), .wdt_irq(src[9]), .wdt_reset(wdt_reset), .usb_wake(src[10]),
    .gpio_group_irq(src[11]), .wdosc_clk(wdosc_clk), .cpu_clk_en(cpu_clk_en), .main_clk_en(main_clk_en),
    .periph_clk_en(periph_clk_en), .wdt_clk_en(wdt_clk_en), .bus_div(bus_div), .analog_pd(analog_pd),
    .irc_out_en(irc_out_en), .flash_standby(flash_standby), .reset_req(reset_req));

  core_irq_model CORE (.mclk(mclk), .srst(srst), .wfi_req(wfi_req), .deep_req(deep_req), .irq_src(src),
    .irq_enabled(irq_enabled), .cpu_clk_en(cpu_clk_en), .core_wfi(core_wfi),
    .deep_idle_select(deep_idle_select), .core_irq_pending(core_irq_pending));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // slow watchdog oscillator; it stands still unless a test lets it run
  always @(posedge mclk)
  begin
    wdosc_div <= wdosc_div + 2'h1;
    if (wdosc_run && wdosc_div == 2'h3)
      wdosc_clk <= ~wdosc_clk;
  end

  always @(posedge mclk)
  begin
    cyc_n++;
    if (cyc_n == 5000)
    begin
      fail_count++;
      end_sim();
    end
  end

  task end_sim;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc

  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [5:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask : rd

  task do_wfi(input logic d);
    @(posedge mclk);
    deep_req <= d;
    @(posedge mclk);
    wfi_req <= 1'b1;
    @(posedge mclk);
    wfi_req <= 1'b0;
    cyc(3);
  endtask : do_wfi

  task go_deep;
    do_wfi(1'b1);
    `CHK(cpu_clk_en, 1'b0)
    `CHK(main_clk_en, 1'b0)
    `CHK(periph_clk_en[14:0], 15'h0)
  endtask : go_deep

  task wake_by(input int i, output int lat);
    @(posedge mclk);
    src[i] <= 1'b1;
    lat = 0;
    while (cpu_clk_en !== 1'b1 && lat < 300)
    begin
      cyc(1);
      lat++;
    end
    `CHK(lat < 300, 1'b1)
    @(posedge mclk);
    src <= 12'h0;
  endtask : wake_by

  task do_reset;
    @(posedge mclk);
    srst <= 1'b1;
    src <= 12'h0;
    wdt_reset <= 1'b0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    cyc(1);
    `CHK(cpu_clk_en, 1'b1)
    `CHK(analog_pd, pwr_mode_pkg::RUN_RST)
    `CHK(reset_req, 1'b0)
  endtask : do_reset

  initial
  begin
    {srst, reg_wr, reg_rd, wfi_req, deep_req, wdt_reset, wdosc_clk, wdosc_run} = 8'h80;
    {reg_addr, reg_wdata, irq_enabled, src, wdosc_div} = '0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd(pwr_mode_pkg::OFS_RUN, {24'h0, pwr_mode_pkg::RUN_RST});
    rd(pwr_mode_pkg::OFS_SLEEP, {24'h0, pwr_mode_pkg::SLEEP_RST});
    rd(pwr_mode_pkg::OFS_WAKE, {24'h0, pwr_mode_pkg::WAKE_RST});
    rd(pwr_mode_pkg::OFS_GATE, {16'h0, pwr_mode_pkg::GATE_RST});
    rd(pwr_mode_pkg::OFS_DIV, {24'h0, pwr_mode_pkg::DIV_RST});
    wr(pwr_mode_pkg::OFS_STATUS, 32'h3);
    rd(pwr_mode_pkg::OFS_STATUS, 32'h0);
    wr(6'h2c, 32'h5a);
    rd(6'h2c, 32'h0);
    `CHK({periph_clk_en, bus_div, irc_out_en, flash_standby}, {16'h001f, 8'h01, 2'h2})
    $display("test reset values done");
    // sleep: only the core clock stops; an interrupt the controller masks must not wake
    wr(pwr_mode_pkg::OFS_DIV, 32'h3);
    wr(pwr_mode_pkg::OFS_RUN, 32'hd0);
    wr(pwr_mode_pkg::OFS_PCTRL, 32'h0);
    irq_enabled <= 12'h001;
    do_wfi(1'b0);
    `CHK({cpu_clk_en, main_clk_en, periph_clk_en, bus_div}, {2'h1, 16'h001f, 8'h03})
    `CHK(analog_pd, 8'hd0)
    rd(pwr_mode_pkg::OFS_STATUS, 32'h1);
    @(posedge mclk);
    src[1] <= 1'b1;
    cyc(10);
    `CHK(cpu_clk_en, 1'b0)
    wake_by(0, n);
    `CHK(n <= 3, 1'b1)
    `CHK({analog_pd, bus_div}, 16'hd003)
    $display("test sleep done");
    // deep-sleep: brownout powered down and pin not in the wake enable must not wake
    wr(pwr_mode_pkg::OFS_SLEEP, 32'hff);
    wr(pwr_mode_pkg::OFS_WAKE, 32'hc0);
    wr(pwr_mode_pkg::OFS_PIN_EN, 32'h08);
    wr(pwr_mode_pkg::OFS_BOD, 32'h1);
    wr(pwr_mode_pkg::OFS_PCTRL, 32'h1);
    irq_enabled <= 12'h10c;
    go_deep();
    `CHK({irc_out_en, flash_standby, analog_pd[pwr_mode_pkg::PD_IRC]}, 3'h2)
    `CHK({analog_pd[7:4], analog_pd[pwr_mode_pkg::PD_BOD]}, 5'h1f)
    @(posedge mclk);
    src <= 12'h104;
    cyc(30);
    `CHK({cpu_clk_en, reset_req}, 2'h0)
    src <= 12'h0;
    wake_by(3, lat_ds);
    `CHK(analog_pd, 8'hc0)
    rd(pwr_mode_pkg::OFS_PIN_EN, 32'h08);
    $display("test deep-sleep done");
    // power-down: usb then gpio group; rc and flash off, slower wake
    wr(pwr_mode_pkg::OFS_WAKE1, 32'hc);
    wr(pwr_mode_pkg::OFS_PCTRL, 32'h2);
    irq_enabled <= 12'hc00;
    go_deep();
    `CHK({analog_pd[pwr_mode_pkg::PD_IRC], analog_pd[pwr_mode_pkg::PD_FLASH]}, 2'h3)
    wake_by(10, lat_pd);
    `CHK(lat_pd > lat_ds, 1'b1)
    go_deep();
    wake_by(11, n);
    $display("test power-down done");
    // watchdog oscillator kept: wake waits for its edges, then a watchdog reset wake
    wr(pwr_mode_pkg::OFS_WDCFG, 32'h5);
    wr(pwr_mode_pkg::OFS_SLEEP, 32'hdf);
    wr(pwr_mode_pkg::OFS_WAKE1, 32'h2);
    wr(pwr_mode_pkg::OFS_GATE, 32'h801f);
    wr(pwr_mode_pkg::OFS_PCTRL, 32'h1);
    irq_enabled <= 12'h200;
    go_deep();
    `CHK({wdt_clk_en, analog_pd[pwr_mode_pkg::PD_WDO]}, 2'h2)
    @(posedge mclk);
    src[9] <= 1'b1;
    cyc(30);
    `CHK(cpu_clk_en, 1'b0)
    wdosc_run <= 1'b1;
    wake_by(9, n);
    wr(pwr_mode_pkg::OFS_WDCFG, 32'h6);
    go_deep();
    wdt_reset <= 1'b1;
    cyc(12);
    `CHK(reset_req, 1'b1)
    wdosc_run <= 1'b0;
    do_reset();
    $display("test watchdog done");
    // brownout kept powered with reset enabled
    wr(pwr_mode_pkg::OFS_SLEEP, 32'hf7);
    wr(pwr_mode_pkg::OFS_BOD, 32'h1);
    wr(pwr_mode_pkg::OFS_PCTRL, 32'h1);
    go_deep();
    src[8] <= 1'b1;
    cyc(12);
    `CHK(reset_req, 1'b1)
    do_reset();
    $display("test brownout done");
    // frozen rc watchdog source: cannot be undone, blocks power-down, keeps rc in deep-sleep
    wr(pwr_mode_pkg::OFS_WDCFG, 32'h20);
    wr(pwr_mode_pkg::OFS_WDCFG, 32'h04);
    rd(pwr_mode_pkg::OFS_WDCFG, 32'h20);
    wr(pwr_mode_pkg::OFS_PCTRL, 32'h2);
    do_wfi(1'b1);
    `CHK(cpu_clk_en, 1'b1)
    wr(pwr_mode_pkg::OFS_PCTRL, 32'h1);
    wr(pwr_mode_pkg::OFS_PIN_EN, 32'h08);
    irq_enabled <= 12'h008;
    go_deep();
    `CHK({wdt_clk_en, analog_pd[pwr_mode_pkg::PD_IRC]}, 2'h2)
    wake_by(3, n);
    do_reset();
    $display("test watchdog freeze done");
    end_sim();
  end
endmodule : reduced_power_mode_control_bench
